// [design/pcs_params.svh]
// constants for the clock source configuration block
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH
`define PCS_OFF_LOOP    12'h010
`define PCS_OFF_PDET    12'h017
`define PCS_OFF_CAL     12'h018
`define PCS_OFF_CPI     12'h019
`define PCS_OFF_VDIV    12'h1E0
`define PCS_OFF_SRC     12'h1E1
`define PCS_OFF_UPD     12'h232
`define PCS_OFF_STAT    12'h240
`define PCS_UPD_VAL     8'h01
`define PCS_RST_LOOP    8'h01
`define PCS_RST_PDET    8'h00
`define PCS_RST_CAL     8'h00
`define PCS_RST_CPI     8'h07
`define PCS_RST_VDIV    8'h02
`define PCS_RST_SRC     8'h00
`define PCS_PWR_ON      2'h0
`define PCS_PWR_OFF     2'h1
`define PCS_CAL_CYCLES  8'h20
`endif

// [design/pcs_pkg.sv]
// types for the clock source configuration block
package pcs_pkg;
	typedef struct packed {
		logic       polarity;
		logic [2:0] pump_mode;
		logic [1:0] power;
	} pcs_loop_t;
	typedef enum logic [2:0] {
		PCS_PUMP_HIZ  = 3'h0,
		PCS_PUMP_UP   = 3'h1,
		PCS_PUMP_DOWN = 3'h2,
		PCS_PUMP_NORM = 3'h3
	} pcs_pump_mode_t;
	typedef enum logic [1:0] {
		PCS_CAL_IDLE = 2'h0,
		PCS_CAL_RUN  = 2'h1,
		PCS_CAL_DONE = 2'h2
	} pcs_cal_t;
	typedef struct packed {
		logic up;
		logic down;
	} pcs_pump_t;
endpackage

// [design/pcs_top.sv]
// configuration, phase detector and calibration control
`timescale 1ns/1ps
`include "pcs_params.svh"
module pcs_top (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [11:0]     wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            ref_div_i,
	input  wire logic            fb_div_i,
	output pcs_pkg::pcs_pump_t   charge_pump_output_o,
	output logic                 loop_pd_o,
	output logic      [2:0]      vco_ratio_o,
	output logic                 div_bypass_o,
	output logic                 src_internal_o,
	output logic      [1:0]      abl_width_o,
	output logic      [2:0]      pump_current_o,
	output logic                 cal_busy_o
);
	import pcs_pkg::*;

	// ----------------------------------------------------------
	// staged and active registers
	// ----------------------------------------------------------
	logic [7:0] st_loop_r, st_loop_nxt, st_pdet_r, st_pdet_nxt;
	logic [7:0] st_cal_r, st_cal_nxt, st_cpi_r, st_cpi_nxt;
	logic [7:0] st_vdiv_r, st_vdiv_nxt, st_src_r, st_src_nxt;
	logic [7:0] ac_loop_r, ac_loop_nxt, ac_pdet_r, ac_pdet_nxt;
	logic [7:0] ac_cal_r, ac_cal_nxt, ac_cpi_r, ac_cpi_nxt;
	logic [7:0] ac_vdiv_r, ac_vdiv_nxt, ac_src_r, ac_src_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic        ack_r, ack_nxt, upd_r, upd_nxt;
	logic        acc;
	logic [7:0]  wb;
	pcs_cal_t    cal_st_r, cal_st_nxt;
	logic [7:0]  cal_cnt_r, cal_cnt_nxt;
	logic        cal_pend_r, cal_pend_nxt, cal_busy_r, cal_busy_nxt;

	assign acc = wb_cyc_i && wb_stb_i && !ack_r;
	assign wb  = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;

	always_comb begin
		st_loop_nxt = st_loop_r;
		st_pdet_nxt = st_pdet_r;
		st_cal_nxt  = st_cal_r;
		st_cpi_nxt  = st_cpi_r;
		st_vdiv_nxt = st_vdiv_r;
		st_src_nxt  = st_src_r;
		dat_nxt     = dat_r;
		ack_nxt     = acc;
		upd_nxt     = 1'b0;
		if (acc && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == `PCS_OFF_LOOP) begin
				st_loop_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_PDET) begin
				st_pdet_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_CAL) begin
				st_cal_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_CPI) begin
				st_cpi_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_VDIV) begin
				st_vdiv_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_SRC) begin
				st_src_nxt = wb;
			end else if (wb_adr_i == `PCS_OFF_UPD) begin
				upd_nxt = (wb == `PCS_UPD_VAL);
			end
		end
		if (acc && !wb_we_i) begin
			dat_nxt = 32'h0000_0000;
			if (wb_adr_i == `PCS_OFF_LOOP) begin
				dat_nxt[7:0] = st_loop_r;
			end else if (wb_adr_i == `PCS_OFF_PDET) begin
				dat_nxt[7:0] = st_pdet_r;
			end else if (wb_adr_i == `PCS_OFF_CAL) begin
				dat_nxt[7:0] = st_cal_r;
			end else if (wb_adr_i == `PCS_OFF_CPI) begin
				dat_nxt[7:0] = st_cpi_r;
			end else if (wb_adr_i == `PCS_OFF_VDIV) begin
				dat_nxt[7:0] = st_vdiv_r;
			end else if (wb_adr_i == `PCS_OFF_SRC) begin
				dat_nxt[7:0] = st_src_r;
			end else if (wb_adr_i == `PCS_OFF_STAT) begin
				dat_nxt[1:0] = {cal_st_r == PCS_CAL_DONE,
				                cal_st_r == PCS_CAL_RUN};
			end
		end
	end

	// copy staged to active only on update
	always_comb begin
		ac_loop_nxt = upd_r ? st_loop_r : ac_loop_r;
		ac_pdet_nxt = upd_r ? st_pdet_r : ac_pdet_r;
		ac_cal_nxt  = upd_r ? st_cal_r  : ac_cal_r;
		ac_cpi_nxt  = upd_r ? st_cpi_r  : ac_cpi_r;
		ac_vdiv_nxt = upd_r ? st_vdiv_r : ac_vdiv_r;
		ac_src_nxt  = upd_r ? st_src_r  : ac_src_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_loop_r <= `PCS_RST_LOOP;
			st_pdet_r <= `PCS_RST_PDET;
			st_cal_r  <= `PCS_RST_CAL;
			st_cpi_r  <= `PCS_RST_CPI;
			st_vdiv_r <= `PCS_RST_VDIV;
			st_src_r  <= `PCS_RST_SRC;
			ac_loop_r <= `PCS_RST_LOOP;
			ac_pdet_r <= `PCS_RST_PDET;
			ac_cal_r  <= `PCS_RST_CAL;
			ac_cpi_r  <= `PCS_RST_CPI;
			ac_vdiv_r <= `PCS_RST_VDIV;
			ac_src_r  <= `PCS_RST_SRC;
			dat_r     <= 32'h0000_0000;
			ack_r     <= 1'b0;
			upd_r     <= 1'b0;
		end else begin
			st_loop_r <= st_loop_nxt;
			st_pdet_r <= st_pdet_nxt;
			st_cal_r  <= st_cal_nxt;
			st_cpi_r  <= st_cpi_nxt;
			st_vdiv_r <= st_vdiv_nxt;
			st_src_r  <= st_src_nxt;
			ac_loop_r <= ac_loop_nxt;
			ac_pdet_r <= ac_pdet_nxt;
			ac_cal_r  <= ac_cal_nxt;
			ac_cpi_r  <= ac_cpi_nxt;
			ac_vdiv_r <= ac_vdiv_nxt;
			ac_src_r  <= ac_src_nxt;
			dat_r     <= dat_nxt;
			ack_r     <= ack_nxt;
			upd_r     <= upd_nxt;
		end
	end

	// ----------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------
	pcs_loop_t  loop;
	logic [2:0] ratio;
	assign loop = {ac_loop_r[7], ac_loop_r[6:4], ac_loop_r[1:0]};
	// codes above four clamp to divide-by-6
	assign ratio = (ac_vdiv_r[2:0] > 3'h4) ? 3'h6
	             : 3'(ac_vdiv_r[2:0] + 3'h2);

	// ----------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------

	always_comb begin
		cal_st_nxt   = cal_st_r;
		cal_cnt_nxt  = cal_cnt_r;
		cal_pend_nxt = cal_pend_r;
		if (upd_r && !st_cal_r[0]) begin
			cal_pend_nxt = 1'b0;
		end else if (upd_r && st_cal_r[0] && !ac_cal_r[0]) begin
			cal_pend_nxt = 1'b1;
		end
		case (cal_st_r)
			PCS_CAL_IDLE: begin
				if (cal_pend_r) begin
					cal_st_nxt   = PCS_CAL_RUN;
					cal_cnt_nxt  = `PCS_CAL_CYCLES;
					cal_pend_nxt = 1'b0;
				end
			end
			PCS_CAL_RUN: begin
				if (cal_cnt_r == 8'h01) begin
					cal_st_nxt = PCS_CAL_DONE;
				end
				cal_cnt_nxt = cal_cnt_r - 8'h01;
			end
			PCS_CAL_DONE: begin
				if (upd_r && !st_cal_r[0]) begin
					cal_st_nxt = PCS_CAL_IDLE;
				end
			end
			default: begin
				cal_st_nxt = PCS_CAL_IDLE;
			end
		endcase
		cal_busy_nxt = (cal_st_nxt == PCS_CAL_RUN);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_st_r   <= PCS_CAL_IDLE;
			cal_cnt_r  <= 8'h00;
			cal_pend_r <= 1'b0;
			cal_busy_r <= 1'b0;
		end else begin
			cal_st_r   <= cal_st_nxt;
			cal_cnt_r  <= cal_cnt_nxt;
			cal_pend_r <= cal_pend_nxt;
			cal_busy_r <= cal_busy_nxt;
		end
	end

	// ----------------------------------------------------------
	// phase detector and charge pump
	// ----------------------------------------------------------
	logic      ref_m_r, ref_s_r, ref_d_r, fb_m_r, fb_s_r, fb_d_r;
	logic      pu_r, pu_nxt, pd_r, pd_nxt;
	logic [1:0] abl_r, abl_nxt;
	logic      ref_e, fb_e;
	pcs_pump_t pump_nxt, pump_r;

	assign ref_e = ref_s_r && !ref_d_r;
	assign fb_e  = fb_s_r && !fb_d_r;

	always_comb begin
		pu_nxt  = pu_r || ref_e;
		pd_nxt  = pd_r || fb_e;
		abl_nxt = abl_r;
		// both high held for one cycle more than the antibacklash width
		if (pu_r && pd_r) begin
			if (abl_r >= ac_pdet_r[1:0]) begin
				pu_nxt  = ref_e;
				pd_nxt  = fb_e;
				abl_nxt = 2'h0;
			end else begin
				abl_nxt = abl_r + 2'h1;
			end
		end
		pump_nxt = loop.polarity ? pcs_pump_t'{up: pd_r, down: pu_r}
		                         : pcs_pump_t'{up: pu_r, down: pd_r};
		case (pcs_pump_mode_t'(loop.pump_mode))
			PCS_PUMP_UP:   pump_nxt = '{up: 1'b1, down: 1'b0};
			PCS_PUMP_DOWN: pump_nxt = '{up: 1'b0, down: 1'b1};
			PCS_PUMP_NORM: pump_nxt = pump_nxt;
			default:       pump_nxt = '{up: 1'b0, down: 1'b0};
		endcase
		if (loop.power != `PCS_PWR_ON) begin
			pump_nxt = '{up: 1'b0, down: 1'b0};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{ref_m_r, ref_s_r, ref_d_r} <= 3'h0;
			{fb_m_r, fb_s_r, fb_d_r}    <= 3'h0;
			pu_r   <= 1'b0;
			pd_r   <= 1'b0;
			abl_r  <= 2'h0;
			pump_r <= '{up: 1'b0, down: 1'b0};
		end else begin
			{ref_m_r, ref_s_r, ref_d_r} <= {ref_div_i, ref_m_r, ref_s_r};
			{fb_m_r, fb_s_r, fb_d_r}    <= {fb_div_i, fb_m_r, fb_s_r};
			pu_r   <= pu_nxt;
			pd_r   <= pd_nxt;
			abl_r  <= abl_nxt;
			pump_r <= pump_nxt;
		end
	end

	// ----------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loop_pd_o      <= 1'b1;
			vco_ratio_o    <= 3'h4;
			div_bypass_o   <= 1'b0;
			src_internal_o <= 1'b0;
			abl_width_o    <= 2'h0;
			pump_current_o <= 3'h7;
		end else begin
			loop_pd_o      <= (loop.power == `PCS_PWR_OFF);
			vco_ratio_o    <= ratio;
			div_bypass_o   <= ac_src_r[0];
			src_internal_o <= ac_src_r[1];
			abl_width_o    <= ac_pdet_r[1:0];
			pump_current_o <= ac_cpi_r[2:0];
		end
	end
	assign charge_pump_output_o = pump_r;
	assign wb_dat_o   = dat_r;
	assign wb_ack_o   = ack_r;
	assign cal_busy_o = cal_busy_r;

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	sequence upd_wr_s;
		acc && wb_we_i && wb_sel_i[0] && (wb_adr_i == `PCS_OFF_UPD)
		&& (wb_dat_i[7:0] == `PCS_UPD_VAL);
	endsequence
	sequence cal_start_s;
		cal_st_r == PCS_CAL_IDLE && cal_pend_r;
	endsequence

	stage_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!upd_r |=> ac_src_r == $past(ac_src_r))
		else $error("active source changed without update");
	stage_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
		upd_wr_s |=> ##1 ac_loop_r == $past(st_loop_r))
		else $error("update did not apply staged loop");
	pwr_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
		loop.power == `PCS_PWR_OFF |=> loop_pd_o && pump_r == 2'h0)
		else $error("power-down not applied");
	bypass_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ac_src_r[0] |=> div_bypass_o)
		else $error("bypass not driven");
	src_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> src_internal_o == $past(ac_src_r[1]))
		else $error("source select wrong");
	force_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
		loop.pump_mode == 3'h1 && loop.power == `PCS_PWR_ON
		|=> pump_r == 2'h2)
		else $error("forced pump-up missing");
	ratio_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ac_vdiv_r[2:0] == 3'h2 |=> vco_ratio_o == 3'h4)
		else $error("divide ratio wrong");
	abl_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pu_r && pd_r |-> ##[0:4] !(pu_r && pd_r) || ref_e || fb_e)
		else $error("antibacklash overran");
	cal_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cal_start_s |=> cal_busy_o ##32 cal_st_r == PCS_CAL_DONE)
		else $error("calibration length wrong");
	cur_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> pump_current_o == $past(ac_cpi_r[2:0]))
		else $error("current step wrong");
endmodule

// [sim/pcs_vco_model.sv]
// stand-in for the external oscillator and the two loop dividers
`timescale 1ns/1ps
module pcs_vco_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [4:0] fb_half_i,
	output logic            ref_div_o,
	output logic            fb_div_o
);
	// ----------------------------------------
	// divider outputs
	// ----------------------------------------
	// open loop on purpose: the bench sets the feedback rate so the
	// expected pump direction is known without modelling the filter
	logic [4:0] ref_cnt_r;
	logic [4:0] fb_cnt_r;
	logic       fb_wrap;
	assign fb_wrap = (fb_cnt_r >= fb_half_i - 5'h01);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_cnt_r <= 5'h00;
			fb_cnt_r  <= 5'h00;
			ref_div_o <= 1'b0;
			fb_div_o  <= 1'b0;
		end else begin
			ref_cnt_r <= (ref_cnt_r == 5'h07) ? 5'h00 : ref_cnt_r + 5'h01;
			fb_cnt_r  <= fb_wrap ? 5'h00 : fb_cnt_r + 5'h01;
			if (ref_cnt_r == 5'h07) begin
				ref_div_o <= ~ref_div_o;
			end
			if (fb_wrap) begin
				fb_div_o <= ~fb_div_o;
			end
		end
	end
endmodule

// [sim/tb.sv]
// self-checking bench for the clock source configuration block
`timescale 1ns/1ps
`include "pcs_params.svh"
module tb;
	import pcs_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic        ack;
	logic        ref_div;
	logic        fb_div;
	pcs_pump_t   pump;
	logic        pd;
	logic [2:0]  ratio;
	logic        byp;
	logic        src_int;
	logic [1:0]  abl;
	logic [2:0]  cpi;
	logic        busy;
	logic [4:0]  fb_half;
	logic [31:0] rd;
	logic [31:0] cur;
	logic [31:0] outs;
	logic [7:0]  f [5];
	logic [11:0] off [5];
	logic [7:0]  pl [8];
	logic [1:0]  pe [8];
	integer      num_errors;
	integer      comparisons;
	integer      seed;
	integer      n_up;
	integer      n_dn;
	integer      i;
	integer      j;
	integer      k;
	assign outs = {21'h0, pd, ratio, byp, src_int, abl, cpi};
	pcs_top i_pcs_top (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .ref_div_i(ref_div),
		.fb_div_i(fb_div), .charge_pump_output_o(pump), .loop_pd_o(pd),
		.vco_ratio_o(ratio), .div_bypass_o(byp), .src_internal_o(src_int),
		.abl_width_o(abl), .pump_current_o(cpi), .cal_busy_o(busy));
	pcs_vco_model i_pcs_vco_model (
		.clk_i(clk_i), .rst_i(rst_i), .fb_half_i(fb_half),
		.ref_div_o(ref_div), .fb_div_o(fb_div));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic close_out;
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [11:0] a,
			input logic [7:0] d);
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= {24'h000000, d};
		@(posedge clk_i);
		while (ack !== 1'b1) begin
			k = k + 1;
			if (k > 50) begin
				num_errors = num_errors + 1;
				close_out;
			end
			@(posedge clk_i);
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// staged values reach the outputs two edges after the update ack
	task automatic settle;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic apply;
		wb(1'b1, `PCS_OFF_UPD, `PCS_UPD_VAL);
		settle;
	endtask
	task automatic watch;
		n_up = 0;
		n_dn = 0;
		repeat (160) begin
			@(posedge clk_i);
			n_up = n_up + pump.up;
			n_dn = n_dn + pump.down;
		end
	endtask
	function automatic logic [31:0] exp_out(input logic [7:0] lp,
			input logic [7:0] dv, input logic [7:0] sr,
			input logic [7:0] pt, input logic [7:0] ci);
		logic [2:0] r;
		r = (dv[2:0] > 3'h4) ? 3'h6 : dv[2:0] + 3'h2;
		return {21'h0, lp[1:0] == `PCS_PWR_OFF, r, sr[0], sr[1],
			pt[1:0], ci[2:0]};
	endfunction
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 12'h000;
		sel = 4'h1;
		dat = 32'h0;
		fb_half = 5'h0C;
		num_errors = 0;
		comparisons = 0;
		seed = 53;
		off = '{`PCS_OFF_LOOP, `PCS_OFF_VDIV, `PCS_OFF_SRC, `PCS_OFF_PDET,
			`PCS_OFF_CPI};
		pl = '{8'h00, 8'h10, 8'h20, 8'h30, 8'hB0, 8'h31, 8'h40, 8'h32};
		pe = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		settle;
		cur = exp_out(`PCS_RST_LOOP, `PCS_RST_VDIV, `PCS_RST_SRC,
			`PCS_RST_PDET, `PCS_RST_CPI);
		chk(outs, cur);
		for (i = 0; i < 6; i = i + 1) begin
			f[0] = (i == 0) ? 8'h30 : 8'($random(seed)) & 8'hB3;
			f[1] = 8'($random(seed)) & 8'h07;
			f[2] = (i == 0) ? 8'h01 : 8'($random(seed)) & 8'h03;
			f[3] = 8'($random(seed)) & 8'h03;
			f[4] = 8'($random(seed)) & 8'h07;
			for (j = 0; j < 5; j = j + 1) begin
				wb(1'b1, off[j], f[j]);
			end
			wb(1'b0, off[0], 8'h00);
			chk(rd, {24'h0, f[0]});
			wb(1'b1, `PCS_OFF_UPD, 8'h02);
			settle;
			chk(outs, cur);
			apply;
			cur = exp_out(f[0], f[1], f[2], f[3], f[4]);
			chk(outs, cur);
		end
		@(posedge clk_i);
		sel <= 4'h0;
		wb(1'b1, `PCS_OFF_VDIV, ~f[1]);
		@(posedge clk_i);
		sel <= 4'h1;
		apply;
		chk(outs, cur);
		wb(1'b1, 12'h100, 8'hFF);
		wb(1'b0, 12'h100, 8'h00);
		chk(rd, 32'h0);
		for (i = 0; i < 8; i = i + 1) begin
			wb(1'b1, `PCS_OFF_LOOP, pl[i]);
			apply;
			watch;
			chk({30'h0, n_up > n_dn, n_dn > n_up}, {30'h0, pe[i]});
		end
		wb(1'b1, `PCS_OFF_CAL, 8'h01);
		apply;
		chk({31'h0, busy}, 32'h1);
		wb(1'b0, `PCS_OFF_STAT, 8'h00);
		chk(rd, 32'h1);
		i = 0;
		while (busy !== 1'b0 && i < 60) begin
			@(posedge clk_i);
			i = i + 1;
		end
		chk({30'h0, busy, i > 20}, 32'h1);
		wb(1'b0, `PCS_OFF_STAT, 8'h00);
		chk(rd, 32'h2);
		wb(1'b1, `PCS_OFF_CAL, 8'h00);
		apply;
		wb(1'b0, `PCS_OFF_STAT, 8'h00);
		chk(rd, 32'h0);
		wb(1'b1, `PCS_OFF_CAL, 8'h01);
		apply;
		chk({31'h0, busy}, 32'h1);
		close_out;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors = num_errors + 1;
		close_out;
	end
endmodule
